// ==== rtl/fdr_defs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit registers, core clock of 25 MHz
// Notes: Definitions only
`ifndef FDR_DEFS_SVH
`define FDR_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FDR_ADDR_CONTROL 8'h06
`define FDR_ADDR_STROBE 8'h07
`define FDR_ADDR_FAULT 8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FDR_CTL_OUT_ON 0
`define FDR_CTL_MODE_LO 4
`define FDR_CTL_MODE_HI 5
`define FDR_STB_TYPE 6
`define FDR_STB_ON 7
`define FDR_FLT_UVLO 0
`define FDR_FLT_TXMASK 3
`define FDR_FLT_TIMEOUT 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FDR_RST_OUT_ON 1'h0
`define FDR_RST_STB_TYPE 1'h1
`define FDR_RST_STB_ON 1'h1
`define FDR_RST_STB_SPARE 6'h00
`define FDR_RST_BYTE 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FDR_CLK_KHZ 25000
`define FDR_STEP_MS 2
`define FDR_STEP_CYC (`FDR_STEP_MS * `FDR_CLK_KHZ)
`define FDR_FINE_LAST 8'h7F
`define FDR_FINE_STEPS 10'h080
`define FDR_COARSE_MUL 4

`endif

// ==== rtl/fdr_pkg.sv ====
// Purpose: Types shared by the flash driver register block
// Assumes: Nothing beyond the defs header
// Notes: Mode codes follow the operating mode field
package fdr_pkg;

  typedef enum logic [1:0] {
    FDR_MODE_SHUTDOWN = 2'h0,
    FDR_MODE_INDICATOR = 2'h1,
    FDR_MODE_ASSIST = 2'h2,
    FDR_MODE_FLASH = 2'h3
  } fdr_mode_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fdr_reg_req_s;

  typedef struct packed {
    logic [7:0] led1;
    logic [7:0] led2;
  } fdr_led_cur_s;

endpackage

// ==== rtl/fdr_flash_timer.sv ====
// Purpose: Flash duration timer, 2ms then 8ms steps
// Assumes: run is low between flashes
// Notes: expired pulses once per flash when the duration is reached
`timescale 1ns/1ps
`default_nettype none
`include "fdr_defs.svh"

module fdr_flash_timer #(
  parameter int STEP_CYC = `FDR_STEP_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [7:0] code,
  output logic expired
);
  import fdr_pkg::*;

  logic [16:0] cyc_ff, nxt_cyc;
  logic [9:0] steps_ff, nxt_steps;
  logic expired_ff, nxt_expired;
  logic done_ff, nxt_done;
  logic [9:0] target;

  // ----------------------------------------------------------------
  // Duration in 2ms units
  // ----------------------------------------------------------------
  always_comb
  begin
    if (code <= `FDR_FINE_LAST)
      target = {2'h0, code} + 10'h001;
    else
      target = 10'((code - `FDR_FINE_LAST) * `FDR_COARSE_MUL)
               + `FDR_FINE_STEPS;
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_cyc = cyc_ff;
    nxt_steps = steps_ff;
    nxt_expired = 1'b0;
    nxt_done = done_ff;
    if (!run)
    begin
      nxt_cyc = '0;
      nxt_steps = '0;
      nxt_done = 1'b0;
    end
    else if (!done_ff)
    begin
      if (cyc_ff == 17'(STEP_CYC - 1))
      begin
        nxt_cyc = '0;
        nxt_steps = steps_ff + 10'h001;
        if (steps_ff + 10'h001 >= target)
        begin
          nxt_expired = 1'b1;
          nxt_done = 1'b1;
        end
      end
      else
        nxt_cyc = cyc_ff + 17'h00001;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cyc_ff <= '0;
      steps_ff <= '0;
      expired_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      cyc_ff <= nxt_cyc;
      steps_ff <= nxt_steps;
      expired_ff <= nxt_expired;
      done_ff <= nxt_done;
    end
  end

  assign expired = expired_ff;

endmodule
`default_nettype wire

// ==== rtl/fdr_regs.sv ====
// Purpose: Control, strobe and fault registers of an LED flash driver
// Assumes: Register requests come decoded from the serial control bus
// Notes: Pin inputs are synchronised; read data is one cycle late
`timescale 1ns/1ps
`default_nettype none
`include "fdr_defs.svh"

module fdr_regs #(
  parameter int STEP_CYC = `FDR_STEP_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire fdr_pkg::fdr_reg_req_s req,
  input wire logic [7:0] flash_timeout,
  input wire fdr_pkg::fdr_led_cur_s led_cur,
  input wire logic strobe_pin,
  input wire logic txmask_pin,
  input wire logic uvlo_pin,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic out_on,
  output fdr_pkg::fdr_mode_e mode,
  output logic flash_active,
  output logic led_sink_pins,
  output fdr_pkg::fdr_led_cur_s led_drive,
  output logic [7:0] fault_flags
);
  import fdr_pkg::*;

  typedef enum logic [1:0] {
    FDR_FS_IDLE = 2'b01,
    FDR_FS_ON = 2'b10
  } fdr_fstate_e;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 3;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_ff, sync2_ff, prev_ff;
  logic strobe_s, txmask_s, uvlo_s, strobe_rise;

  assign pin_raw = {uvlo_pin, txmask_pin, strobe_pin};

  generate
    for (genvar i = 0; i < NPIN; i++)
    begin : g_sync
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          sync1_ff[i] <= 1'b0;
          sync2_ff[i] <= 1'b0;
          prev_ff[i] <= 1'b0;
        end
        else
        begin
          sync1_ff[i] <= pin_raw[i];
          sync2_ff[i] <= sync1_ff[i];
          prev_ff[i] <= sync2_ff[i];
        end
      end
    end
  endgenerate

  assign strobe_s = sync2_ff[0];
  assign txmask_s = sync2_ff[1];
  assign uvlo_s = sync2_ff[2];
  assign strobe_rise = sync2_ff[0] & ~prev_ff[0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic out_on_ff, nxt_out_on;
  fdr_mode_e mode_ff, nxt_mode;
  logic stb_type_ff, nxt_stb_type;
  logic stb_on_ff, nxt_stb_on;
  logic [5:0] stb_spare_ff, nxt_stb_spare;
  logic flt_uvlo_ff, nxt_flt_uvlo;
  logic flt_txmask_ff, nxt_flt_txmask;
  logic flt_timeout_ff, nxt_flt_timeout;
  fdr_fstate_e fst_ff, nxt_fst;
  logic [7:0] rd_data_ff, nxt_rd_data;
  logic rd_valid_ff, nxt_rd_valid;
  logic sink_ff, nxt_sink;
  logic active_ff, nxt_active;
  fdr_led_cur_s drive_ff, nxt_drive;
  logic expired;
  logic armed, start, flash_end, level_drop, sw_abort;
  logic wr_ctl, wr_stb, rd_flt;
  logic [7:0] ctl_view, stb_view, flt_view;

  fdr_flash_timer #(
    .STEP_CYC(STEP_CYC)
  ) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .run(fst_ff == FDR_FS_ON),
    .code(flash_timeout),
    .expired(expired)
  );

  // ----------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------
  always_comb
  begin
    ctl_view = `FDR_RST_BYTE;
    ctl_view[`FDR_CTL_OUT_ON] = out_on_ff;
    ctl_view[`FDR_CTL_MODE_HI:`FDR_CTL_MODE_LO] = mode_ff;
    stb_view = {stb_on_ff, stb_type_ff, stb_spare_ff};
    flt_view = `FDR_RST_BYTE;
    flt_view[`FDR_FLT_UVLO] = flt_uvlo_ff;
    flt_view[`FDR_FLT_TXMASK] = flt_txmask_ff;
    flt_view[`FDR_FLT_TIMEOUT] = flt_timeout_ff;
  end

  assign wr_ctl = req.wr && req.addr == `FDR_ADDR_CONTROL;
  assign wr_stb = req.wr && req.addr == `FDR_ADDR_STROBE;
  assign rd_flt = req.rd && req.addr == `FDR_ADDR_FAULT;

  // ----------------------------------------------------------------
  // Flash sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    armed = out_on_ff && mode_ff == FDR_MODE_FLASH;
    start = 1'b0;
    if (armed)
    begin
      if (!stb_on_ff)
        start = 1'b1;
      else if (stb_type_ff)
        start = strobe_s;
      else
        start = strobe_rise;
    end
    sw_abort = !armed;
    level_drop = stb_on_ff && stb_type_ff && !strobe_s;
    flash_end = fst_ff == FDR_FS_ON
                && (expired || level_drop || sw_abort);
  end

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_out_on = out_on_ff;
    nxt_mode = mode_ff;
    nxt_stb_type = stb_type_ff;
    nxt_stb_on = stb_on_ff;
    nxt_stb_spare = stb_spare_ff;
    nxt_fst = fst_ff;
    nxt_rd_data = rd_data_ff;
    nxt_rd_valid = 1'b0;
    nxt_flt_uvlo = flt_uvlo_ff;
    nxt_flt_txmask = flt_txmask_ff;
    nxt_flt_timeout = flt_timeout_ff;

    unique case (fst_ff)
      FDR_FS_IDLE:
        if (start)
          nxt_fst = FDR_FS_ON;
      FDR_FS_ON:
        if (flash_end)
        begin
          nxt_fst = FDR_FS_IDLE;
          nxt_out_on = 1'b0;
          nxt_mode = FDR_MODE_SHUTDOWN;
        end
    endcase

    // Software writes land after the auto clear so a rewrite is kept
    if (wr_ctl)
    begin
      nxt_out_on = req.wdata[`FDR_CTL_OUT_ON];
      nxt_mode = fdr_mode_e'(req.wdata[`FDR_CTL_MODE_HI:`FDR_CTL_MODE_LO]);
    end
    if (wr_stb)
    begin
      nxt_stb_type = req.wdata[`FDR_STB_TYPE];
      nxt_stb_on = req.wdata[`FDR_STB_ON];
      nxt_stb_spare = req.wdata[5:0];
    end

    nxt_rd_valid = req.rd;
    if (req.rd)
    begin
      unique case (req.addr)
        `FDR_ADDR_CONTROL: nxt_rd_data = ctl_view;
        `FDR_ADDR_STROBE: nxt_rd_data = stb_view;
        `FDR_ADDR_FAULT: nxt_rd_data = flt_view;
        default: nxt_rd_data = `FDR_RST_BYTE;
      endcase
    end

    // Clear on read first, then sets so a same-cycle event survives
    if (rd_flt)
    begin
      nxt_flt_uvlo = 1'b0;
      nxt_flt_txmask = 1'b0;
      nxt_flt_timeout = 1'b0;
    end
    if (uvlo_s)
      nxt_flt_uvlo = 1'b1;
    if (txmask_s && fst_ff == FDR_FS_ON)
      nxt_flt_txmask = 1'b1;
    // An edge strobe flash is meant to end on the timer, not a fault
    if (fst_ff == FDR_FS_ON && expired && !(stb_on_ff && !stb_type_ff))
      nxt_flt_timeout = 1'b1;

    nxt_sink = nxt_out_on;
    // Own flop so the flash flag leaves no decode gate on the pin
    nxt_active = nxt_fst == FDR_FS_ON;
    nxt_drive = '0;
    if (nxt_out_on)
    begin
      unique case (nxt_mode)
        FDR_MODE_SHUTDOWN: nxt_drive = '0;
        FDR_MODE_INDICATOR:
        begin
          nxt_drive.led1 = {2'h0, led_cur.led1[5:0]};
          nxt_drive.led2 = {2'h0, led_cur.led2[5:0]};
        end
        FDR_MODE_ASSIST:
        begin
          nxt_drive.led1 = {1'b0, led_cur.led1[6:0]};
          nxt_drive.led2 = {1'b0, led_cur.led2[6:0]};
        end
        FDR_MODE_FLASH:
          if (nxt_fst == FDR_FS_ON)
            nxt_drive = led_cur;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      out_on_ff <= `FDR_RST_OUT_ON;
      mode_ff <= FDR_MODE_SHUTDOWN;
      stb_type_ff <= `FDR_RST_STB_TYPE;
      stb_on_ff <= `FDR_RST_STB_ON;
      stb_spare_ff <= `FDR_RST_STB_SPARE;
      flt_uvlo_ff <= 1'b0;
      flt_txmask_ff <= 1'b0;
      flt_timeout_ff <= 1'b0;
      fst_ff <= FDR_FS_IDLE;
      rd_data_ff <= `FDR_RST_BYTE;
      rd_valid_ff <= 1'b0;
      sink_ff <= 1'b0;
      active_ff <= 1'b0;
      drive_ff <= '0;
    end
    else
    begin
      out_on_ff <= nxt_out_on;
      mode_ff <= nxt_mode;
      stb_type_ff <= nxt_stb_type;
      stb_on_ff <= nxt_stb_on;
      stb_spare_ff <= nxt_stb_spare;
      flt_uvlo_ff <= nxt_flt_uvlo;
      flt_txmask_ff <= nxt_flt_txmask;
      flt_timeout_ff <= nxt_flt_timeout;
      fst_ff <= nxt_fst;
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
      sink_ff <= nxt_sink;
      active_ff <= nxt_active;
      drive_ff <= nxt_drive;
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign out_on = out_on_ff;
  assign mode = mode_ff;
  assign flash_active = active_ff;
  assign led_sink_pins = sink_ff;
  assign led_drive = drive_ff;
  assign fault_flags = flt_view;

endmodule
`default_nettype wire

// ==== sim/fdr_regs_monitor.sv ====
// Purpose: Port checks of the flash driver register block
// Assumes: Pins pass two sync flops inside the design
// Notes: Three-cycle pin runs cover the sync latency
`timescale 1ns/1ps
`default_nettype none
module fdr_regs_monitor #(
  parameter int STEP_CYC = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire fdr_pkg::fdr_reg_req_s req,
  input wire logic [7:0] flash_timeout,
  input wire fdr_pkg::fdr_led_cur_s led_cur,
  input wire logic strobe_pin,
  input wire logic txmask_pin,
  input wire logic uvlo_pin,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic out_on,
  input wire fdr_pkg::fdr_mode_e mode,
  input wire logic flash_active,
  input wire logic led_sink_pins,
  input wire fdr_pkg::fdr_led_cur_s led_drive,
  input wire logic [7:0] fault_flags
);
  import fdr_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_rd_ans;
    req.rd |=> rd_valid;
  endproperty
  property p_rd_quiet;
    !req.rd |=> !rd_valid;
  endproperty
  property p_resv;
    fault_flags[2:1] == 2'h0;
  endproperty
  property p_uvlo;
    uvlo_pin [*3] |=> fault_flags[0];
  endproperty
  property p_stick;
    fault_flags[0] && !(req.rd && req.addr == 8'h08) |=> fault_flags[0];
  endproperty
  property p_clear;
    (!uvlo_pin && !txmask_pin) [*3] ##0 (req.rd && req.addr == 8'h08)
      |=> !fault_flags[0] && !fault_flags[3];
  endproperty
  property p_txm;
    (txmask_pin && flash_active) [*3] |=> fault_flags[3];
  endproperty
  property p_sink;
    led_sink_pins == out_on;
  endproperty
  property p_end;
    $fell(flash_active) && !$past(req.wr)
      |-> !out_on && mode == FDR_MODE_SHUTDOWN;
  endproperty
  property p_assist;
    out_on && mode == FDR_MODE_ASSIST && $past(out_on)
      && $past(mode) == FDR_MODE_ASSIST && $stable(led_cur)
      |-> led_drive == {1'h0, led_cur.led1[6:0], 1'h0, led_cur.led2[6:0]};
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read valid without read");
  a_resv: assert property (p_resv)
    else $error("reserved fault bits set");
  a_uvlo: assert property (p_uvlo)
    else $error("undervoltage flag not set");
  a_stick: assert property (p_stick)
    else $error("fault flag lost without read");
  a_clear: assert property (p_clear)
    else $error("fault flags not cleared by read");
  a_txm: assert property (p_txm)
    else $error("transmit mask flag not set");
  a_sink: assert property (p_sink)
    else $error("sinks not enabled");
  a_end: assert property (p_end)
    else $error("flash end left enable or mode");
  a_assist: assert property (p_assist)
    else $error("assist drive keeps top bit");
  c_flash: cover property ($rose(flash_active));
  c_fread: cover property (req.rd && req.addr == 8'h08 && fault_flags[4]);
  c_assist: cover property (out_on && mode == FDR_MODE_ASSIST);
endmodule
`default_nettype wire

// ==== sim/fdr_host_model.sv ====
// Purpose: Host on the decoded register request port
// Assumes: Called from the bench, one transfer at a time
// Notes: Released address and data show inverted junk
`timescale 1ns/1ps
`default_nettype none
module fdr_host_model (
  input wire logic core_clk,
  output var fdr_pkg::fdr_reg_req_s req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  import fdr_pkg::*;
  initial req = '0;
  // Strobes change only at falling edges, so a release never meets a raise
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(negedge core_clk);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge core_clk);
    q = rd_valid ? rd_data : 8'hXX;
    req = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: Directed test of the flash driver register block
// Assumes: Timer step shortened to four cycles
// Notes: Flash length is checked within a small window
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fdr_pkg::*;
  localparam int STEP = 4;
  logic core_clk, rst, strobe_pin, txmask_pin, uvlo_pin;
  logic rd_valid, out_on, flash_active, led_sink_pins;
  logic [7:0] flash_timeout, rd_data, fault_flags;
  fdr_reg_req_s req;
  fdr_led_cur_s led_cur, led_drive;
  fdr_mode_e mode;
  int miscompares, check_count, n;
  logic [7:0] codes [2] = '{8'h01, 8'h80};
  int steps [2] = '{2, 132};
  logic [15:0] drv [3] = '{16'h0000, 16'h3F2A, 16'h7F2A};
  fdr_regs #(.STEP_CYC(STEP)) fdr_regs_inst (.core_clk(core_clk),
    .rst(rst), .req(req), .flash_timeout(flash_timeout),
    .led_cur(led_cur), .strobe_pin(strobe_pin), .txmask_pin(txmask_pin),
    .uvlo_pin(uvlo_pin), .rd_data(rd_data), .rd_valid(rd_valid),
    .out_on(out_on), .mode(mode), .flash_active(flash_active),
    .led_sink_pins(led_sink_pins), .led_drive(led_drive),
    .fault_flags(fault_flags));
  fdr_host_model fdr_host_model_inst (.core_clk(core_clk), .req(req),
    .rd_data(rd_data), .rd_valid(rd_valid));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done;
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    fdr_host_model_inst.xfer(1'h1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    fdr_host_model_inst.xfer(1'h0, a, 8'h00, q);
    cmp_byte(q, exp);
  endtask
  // A stuck flash must not hang the run
  task automatic wait_lvl(input logic lvl);
    n = 0;
    while (flash_active !== lvl && n < 3000)
    begin
      @(negedge core_clk);
      n++;
    end
    if (flash_active !== lvl)
    begin
      miscompares++;
      test_done();
    end
  endtask
  initial
  begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  initial
  begin
    rst = 1'h1;
    flash_timeout = 8'h01;
    led_cur = 16'hFFAA;
    strobe_pin = 1'h0;
    txmask_pin = 1'h0;
    uvlo_pin = 1'h0;
    miscompares = 0;
    check_count = 0;
    repeat (2) @(negedge core_clk);
    rst = 1'h0;
    rd_chk(8'h06, 8'h00);
    rd_chk(8'h07, 8'hC0);
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h09, 8'h00);
    wr(8'h08, 8'hFF);
    rd_chk(8'h08, 8'h00);
    wr(8'h07, 8'h3F);
    rd_chk(8'h07, 8'h3F);
    for (int m = 0; m < 3; m++)
    begin
      wr(8'h06, {2'h0, 2'(m), 4'h1});
      rd_chk(8'h06, {2'h0, 2'(m), 4'h1});
      cmp_word(led_drive, drv[m]);
      cmp_byte({7'h00, led_sink_pins}, 8'h01);
    end
    foreach (codes[i])
    begin
      flash_timeout = codes[i];
      wr(8'h06, 8'h31);
      wait_lvl(1'h1);
      cmp_word(led_drive, led_cur);
      txmask_pin = i[0];
      repeat (4) @(negedge core_clk);
      txmask_pin = 1'h0;
      wait_lvl(1'h0);
      n = n + 4;
      cmp_byte(8'(n >= steps[i] * STEP - 1 && n <= steps[i] * STEP + 2),
        8'h01);
      rd_chk(8'h06, 8'h00);
      rd_chk(8'h08, i[0] ? 8'h18 : 8'h10);
      rd_chk(8'h08, 8'h00);
    end
    uvlo_pin = 1'h1;
    txmask_pin = 1'h1;
    repeat (4) @(negedge core_clk);
    uvlo_pin = 1'h0;
    txmask_pin = 1'h0;
    repeat (8) @(negedge core_clk);
    rd_chk(8'h08, 8'h01);
    rd_chk(8'h08, 8'h00);
    wr(8'h07, 8'hC0);
    wr(8'h06, 8'h31);
    repeat (6) @(negedge core_clk);
    cmp_byte({7'h00, flash_active}, 8'h00);
    strobe_pin = 1'h1;
    wait_lvl(1'h1);
    strobe_pin = 1'h0;
    wait_lvl(1'h0);
    rd_chk(8'h06, 8'h00);
    rd_chk(8'h08, 8'h00);
    // Edge strobe: a held pin neither ends the flash nor restarts it
    flash_timeout = 8'h01;
    wr(8'h07, 8'h80);
    wr(8'h06, 8'h31);
    repeat (6) @(negedge core_clk);
    cmp_byte({7'h00, flash_active}, 8'h00);
    strobe_pin = 1'h1;
    wait_lvl(1'h1);
    wait_lvl(1'h0);
    n = n + 1;
    cmp_byte(8'(n >= 2 * STEP - 1 && n <= 2 * STEP + 2), 8'h01);
    strobe_pin = 1'h0;
    rd_chk(8'h06, 8'h00);
    rd_chk(8'h08, 8'h00);
    test_done();
  end
endmodule
bind fdr_regs fdr_regs_monitor #(.STEP_CYC(STEP_CYC)) fdr_regs_monitor_inst (
  .core_clk(core_clk), .rst(rst), .req(req),
  .flash_timeout(flash_timeout), .led_cur(led_cur),
  .strobe_pin(strobe_pin), .txmask_pin(txmask_pin), .uvlo_pin(uvlo_pin),
  .rd_data(rd_data), .rd_valid(rd_valid), .out_on(out_on), .mode(mode),
  .flash_active(flash_active), .led_sink_pins(led_sink_pins),
  .led_drive(led_drive), .fault_flags(fault_flags));
`default_nettype wire
